// ===== bxz_pkg.sv
/*
 * Package for the bit exclusive-OR, bit-test-skip-clear and long call execution block.
 * Assumes a nibble-wide data memory with 12-bit addresses and a 14-bit program counter.
 */
`default_nettype none
package bxz_pkg;
    // First-byte opcodes.
    localparam logic [7:0]  OPC_BIT_XOR   = 8'hF7;
    localparam logic [7:0]  OPC_BIT_TSC   = 8'hFD;
    localparam logic [7:0]  OPC_LCALL     = 8'hDB;
    // Second-byte form fields, bits 7-6; indexed-form pad, bits 5-4.
    localparam logic [1:0]  FORM_HIGH     = 2'h0;
    localparam logic [1:0]  FORM_INDEX    = 2'h1;
    localparam logic [1:0]  FORM_FIXB     = 2'h2;
    localparam logic [1:0]  FORM_FIXF     = 2'h3;
    localparam logic [1:0]  INDEX_PAD     = 2'h0;
    localparam logic [1:0]  LCALL_TAG     = 2'h1;
    // Address pages.
    localparam logic [3:0]  INDEX_PAGE    = 4'hF;
    localparam logic [1:0]  INDEX_TOP     = 2'h3;
    localparam logic [7:0]  PAGE_FIXB     = 8'hFB;
    localparam logic [7:0]  PAGE_FIXF     = 8'hFF;
    localparam logic [3:0]  HIGH_PAGE     = 4'h0;
    localparam logic [3:0]  STACK_PAGE    = 4'h0;
    // Call arithmetic and cycle counts.
    localparam logic [13:0] RET_OFS       = 14'h0003;
    localparam logic [7:0]  SP_DROP       = 8'h06;
    localparam logic [1:0]  PUSH_LAST     = 2'h2;
    localparam int          BIT_OP_CYCLES = 2;
    localparam int          LCALL_CYCLES  = 4;
    // Reset values.
    localparam logic [13:0] PC_RST        = 14'h0000;
    localparam logic [7:0]  SP_RST        = 8'h00;
    localparam logic [1:0]  CNT_RST       = 2'h0;

    typedef enum {ST_IDLE, ST_BIT_RD, ST_BIT_WB, ST_SKIP, ST_CALL_PUSH, ST_CALL_JMP} bxz_state_t;
    typedef enum logic [1:0] {OP_NONE, OP_XOR, OP_TSC, OP_CALL} bxz_op_t;

    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
    } bxz_instr_t;

    typedef struct packed {
        logic [13:0] pc;
        logic [7:0]  sp;
        logic [3:0]  l;
        logic [3:0]  h;
        logic        carry;
        logic        mbank;
        logic        rbank;
    } bxz_ctx_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        pair;
        logic [11:0] addr;
        logic [11:0] addr_hi;
        logic [7:0]  wdata;
    } bxz_mem_t;
endpackage : bxz_pkg
`default_nettype wire

// ===== bxz_bit_addr.sv
/*
 * Bit operand address decoder for the four bit-addressing forms.
 * Assumes the caller has already checked the first opcode byte.
 */
`timescale 1ns/100ps
`default_nettype none
module bxz_bit_addr (
    // Operand inputs.
    input  wire logic [7:0]  opc1,
    input  wire logic [3:0]  l,
    input  wire logic [3:0]  h,
    // Decoded operand.
    output logic      [11:0] addr,
    output logic      [1:0]  bit_sel,
    output logic             ok
);
    import bxz_pkg::*;

    always_comb begin
        addr    = 12'h000;
        bit_sel = opc1[5:4];
        ok      = 1'b1;
        case (opc1[7:6])
            FORM_INDEX: begin
                addr    = {INDEX_PAGE, INDEX_TOP, opc1[3:0], l[3:2]};
                bit_sel = l[1:0];
                ok      = (opc1[5:4] == INDEX_PAD);
            end
            FORM_HIGH: begin
                addr = {HIGH_PAGE, h, opc1[3:0]};
            end
            FORM_FIXB: begin
                addr = {PAGE_FIXB, opc1[3:0]};
            end
            default: begin
                addr = {PAGE_FIXF, opc1[3:0]};
            end
        endcase
    end
endmodule : bxz_bit_addr
`default_nettype wire

// ===== bxz_stack_pair.sv
/*
 * Builds one two-nibble stack write of the long call context push.
 * Assumes stack locations live in page zero and wrap within 256 nibbles.
 */
`timescale 1ns/100ps
`default_nettype none
module bxz_stack_pair (
    // Push context.
    input  wire logic [1:0]  step,
    input  wire logic [7:0]  sp,
    input  wire logic [13:0] ret,
    input  wire logic        mbank,
    input  wire logic        rbank,
    // Pair write.
    output logic      [11:0] addr_lo,
    output logic      [11:0] addr_hi,
    output logic      [7:0]  wdata
);
    import bxz_pkg::*;

    logic [7:0] lo;
    logic [7:0] hi;

    always_comb begin
        lo      = sp - {5'h00, 2'(step + 2'h1), 1'b0};
        hi      = 8'(lo + 8'h01);
        addr_lo = {STACK_PAGE, lo};
        addr_hi = {STACK_PAGE, hi};
        case (step)
            2'h0: wdata = {4'h0, 2'h0, mbank, rbank};
            2'h1: wdata = ret[7:0];
            default: wdata = {2'h0, ret[13:12], ret[11:8]};
        endcase
    end
endmodule : bxz_stack_pair
`default_nettype wire

// ===== bxz_exec.sv
/*
 * Execution unit for bit exclusive-OR, bit-test-skip-clear and the long subroutine call.
 * Assumes a data memory with combinational read in the cycle the read request stands,
 * and writes taken on the clock edge that ends the request cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module bxz_exec (
    // Clock and reset.
    input  wire logic               REF_CLK,
    input  wire logic               RSTN,
    // Instruction issue.
    input  wire logic               START,
    input  wire bxz_pkg::bxz_instr_t INSTR,
    input  wire bxz_pkg::bxz_ctx_t  CTX_IN,
    input  wire logic [1:0]         NEXT_LEN,
    // Data memory.
    output var bxz_pkg::bxz_mem_t   MEM_REQ,
    input  wire logic [3:0]         MEM_RDATA,
    // Core state updates.
    output logic                    CARRY_OUT,
    output logic                    CARRY_WE,
    output logic [13:0]             PC_OUT,
    output logic                    PC_WE,
    output logic [7:0]              SP_OUT,
    output logic                    SP_WE,
    // Status.
    output logic                    BUSY,
    output logic                    DONE,
    output logic                    SKIP_TAKEN,
    output logic                    BAD_OP
);
    import bxz_pkg::*;

    bxz_state_t  state_r, state_nxt;
    bxz_op_t     op_r, op_nxt, dec_op;
    bxz_ctx_t    ctx_r, ctx_nxt, ctx_src;
    bxz_mem_t    mem_r, mem_nxt;
    logic [13:0] target_r, target_nxt;
    logic [1:0]  bit_r, bit_nxt;
    logic [1:0]  step_r, step_nxt, step_sel;
    logic [1:0]  cnt_r, cnt_nxt, len_eff;
    logic        carry_r, carry_nxt;
    logic        carry_we_r, carry_we_nxt;
    logic [13:0] pc_r, pc_nxt;
    logic        pc_we_r, pc_we_nxt;
    logic [7:0]  sp_r, sp_nxt;
    logic        sp_we_r, sp_we_nxt;
    logic        busy_r, busy_nxt;
    logic        done_r, done_nxt;
    logic        skip_r, skip_nxt;
    logic        bad_r, bad_nxt;
    logic        rbit;
    logic        call_ok;
    logic [11:0] ba_addr;
    logic [1:0]  ba_bit;
    logic        ba_ok;
    logic [11:0] sp_addr_lo;
    logic [11:0] sp_addr_hi;
    logic [7:0]  sp_wdata;
    logic [13:0] ret_src;
    logic [13:0] ret_w;

    bxz_bit_addr u_bit_addr (
        .opc1    (INSTR.b1),
        .l       (CTX_IN.l),
        .h       (CTX_IN.h),
        .addr    (ba_addr),
        .bit_sel (ba_bit),
        .ok      (ba_ok)
    );

    assign ctx_src  = (state_r == ST_IDLE) ? CTX_IN : ctx_r;
    assign ret_src  = 14'(ctx_src.pc + RET_OFS);
    assign ret_w    = 14'(ctx_r.pc + RET_OFS);
    assign step_sel = (state_r == ST_IDLE) ? 2'h0 : 2'(step_r + 2'h1);

    bxz_stack_pair u_stack_pair (
        .step    (step_sel),
        .sp      (ctx_src.sp),
        .ret     (ret_src),
        .mbank   (ctx_src.mbank),
        .rbank   (ctx_src.rbank),
        .addr_lo (sp_addr_lo),
        .addr_hi (sp_addr_hi),
        .wdata   (sp_wdata)
    );

    assign call_ok = (INSTR.b1[7:6] == LCALL_TAG);
    assign rbit    = MEM_RDATA[bit_r];
    assign len_eff = (NEXT_LEN == 2'h0) ? 2'h1 : NEXT_LEN;

    always_comb begin
        case (INSTR.b0)
            OPC_BIT_XOR: dec_op = OP_XOR;
            OPC_BIT_TSC: dec_op = OP_TSC;
            OPC_LCALL:   dec_op = OP_CALL;
            default:     dec_op = OP_NONE;
        endcase
    end

    always_comb begin
        state_nxt    = state_r;
        op_nxt       = op_r;
        ctx_nxt      = ctx_r;
        target_nxt   = target_r;
        bit_nxt      = bit_r;
        step_nxt     = step_r;
        cnt_nxt      = cnt_r;
        carry_nxt    = carry_r;
        pc_nxt       = pc_r;
        sp_nxt       = sp_r;
        mem_nxt      = '0;
        carry_we_nxt = 1'b0;
        pc_we_nxt    = 1'b0;
        sp_we_nxt    = 1'b0;
        done_nxt     = 1'b0;
        skip_nxt     = 1'b0;
        bad_nxt      = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (START) begin
                    ctx_nxt = CTX_IN;
                    op_nxt  = dec_op;
                    if ((dec_op == OP_XOR || dec_op == OP_TSC) && ba_ok) begin
                        state_nxt    = ST_BIT_RD;
                        bit_nxt      = ba_bit;
                        mem_nxt.rd   = 1'b1;
                        mem_nxt.addr = ba_addr;
                    end else if (dec_op == OP_CALL && call_ok) begin
                        state_nxt       = ST_CALL_PUSH;
                        step_nxt        = 2'h0;
                        target_nxt      = {INSTR.b1[5:0], INSTR.b2};
                        mem_nxt.wr      = 1'b1;
                        mem_nxt.pair    = 1'b1;
                        mem_nxt.addr    = sp_addr_lo;
                        mem_nxt.addr_hi = sp_addr_hi;
                        mem_nxt.wdata   = sp_wdata;
                    end else begin
                        bad_nxt = 1'b1;
                    end
                end
            end
            ST_BIT_RD: begin
                state_nxt = ST_BIT_WB;
                if (op_r == OP_XOR) begin
                    carry_nxt    = ctx_r.carry ^ rbit;
                    carry_we_nxt = 1'b1;
                    done_nxt     = 1'b1;
                end else begin
                    mem_nxt.wr    = 1'b1;
                    mem_nxt.addr  = mem_r.addr;
                    mem_nxt.wdata = {4'h0, MEM_RDATA & ~(4'h1 << bit_r)};
                    skip_nxt      = rbit;
                    done_nxt      = !rbit;
                end
            end
            ST_BIT_WB: begin
                if (skip_r) begin
                    state_nxt = ST_SKIP;
                    cnt_nxt   = len_eff;
                    done_nxt  = (len_eff == 2'h1);
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_SKIP: begin
                if (cnt_r == 2'h1) begin
                    state_nxt = ST_IDLE;
                end else begin
                    cnt_nxt  = 2'(cnt_r - 2'h1);
                    done_nxt = (cnt_r == 2'h2);
                end
            end
            ST_CALL_PUSH: begin
                if (step_r == PUSH_LAST) begin
                    state_nxt = ST_CALL_JMP;
                    pc_nxt    = target_r;
                    pc_we_nxt = 1'b1;
                    sp_nxt    = ctx_r.sp - SP_DROP;
                    sp_we_nxt = 1'b1;
                    done_nxt  = 1'b1;
                end else begin
                    step_nxt        = step_sel;
                    mem_nxt.wr      = 1'b1;
                    mem_nxt.pair    = 1'b1;
                    mem_nxt.addr    = sp_addr_lo;
                    mem_nxt.addr_hi = sp_addr_hi;
                    mem_nxt.wdata   = sp_wdata;
                end
            end
            ST_CALL_JMP: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != ST_IDLE);
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r    <= ST_IDLE;
            op_r       <= OP_NONE;
            ctx_r      <= '0;
            target_r   <= PC_RST;
            bit_r      <= 2'h0;
            step_r     <= 2'h0;
            cnt_r      <= CNT_RST;
            mem_r      <= '0;
            carry_r    <= 1'b0;
            carry_we_r <= 1'b0;
            pc_r       <= PC_RST;
            pc_we_r    <= 1'b0;
            sp_r       <= SP_RST;
            sp_we_r    <= 1'b0;
            busy_r     <= 1'b0;
            done_r     <= 1'b0;
            skip_r     <= 1'b0;
            bad_r      <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            op_r       <= op_nxt;
            ctx_r      <= ctx_nxt;
            target_r   <= target_nxt;
            bit_r      <= bit_nxt;
            step_r     <= step_nxt;
            cnt_r      <= cnt_nxt;
            mem_r      <= mem_nxt;
            carry_r    <= carry_nxt;
            carry_we_r <= carry_we_nxt;
            pc_r       <= pc_nxt;
            pc_we_r    <= pc_we_nxt;
            sp_r       <= sp_nxt;
            sp_we_r    <= sp_we_nxt;
            busy_r     <= busy_nxt;
            done_r     <= done_nxt;
            skip_r     <= skip_nxt;
            bad_r      <= bad_nxt;
        end
    end

    assign MEM_REQ    = mem_r;
    assign CARRY_OUT  = carry_r;
    assign CARRY_WE   = carry_we_r;
    assign PC_OUT     = pc_r;
    assign PC_WE      = pc_we_r;
    assign SP_OUT     = sp_r;
    assign SP_WE      = sp_we_r;
    assign BUSY       = busy_r;
    assign DONE       = done_r;
    assign SKIP_TAKEN = skip_r;
    assign BAD_OP     = bad_r;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    sequence bit_start(bxz_op_t op);
        state_r == ST_IDLE && START && dec_op == op && ba_ok;
    endsequence
    sequence call_start;
        state_r == ST_IDLE && START && dec_op == OP_CALL && call_ok;
    endsequence
    sequence push_walk;
        MEM_REQ.wr && MEM_REQ.pair ##1 MEM_REQ.wr ##1 MEM_REQ.wr ##1 (DONE && PC_WE && SP_WE && !MEM_REQ.wr);
    endsequence

    bit_xor_carry_op_carry_a: assert property (
        (state_r == ST_BIT_RD && op_r == OP_XOR) |=> CARRY_WE && !MEM_REQ.wr
            && CARRY_OUT == ($past(ctx_r.carry) ^ $past(rbit)))
        else $error("bit XOR carry result wrong");
    bit_xor_carry_op_two_cycle_a: assert property (
        bit_start(OP_XOR) |=> !DONE ##1 DONE ##1 !BUSY)
        else $error("bit XOR did not finish in two cycles");
    index_addr_a: assert property (
        (bit_start(OP_XOR) and INSTR.b1[7:6] == FORM_INDEX) |=> MEM_REQ.rd
            && MEM_REQ.addr == {INDEX_PAGE, INDEX_TOP, $past(INSTR.b1[3:0]), $past(CTX_IN.l[3:2])}
            && bit_r == $past(CTX_IN.l[1:0]))
        else $error("indexed bit address wrong");
    high_addr_a: assert property (
        (bit_start(OP_TSC) and INSTR.b1[7:6] == FORM_HIGH) |=>
            MEM_REQ.addr == {HIGH_PAGE, $past(CTX_IN.h), $past(INSTR.b1[3:0])})
        else $error("high register bit address wrong");
    fixed_addr_a: assert property (
        (bit_start(OP_XOR) and INSTR.b1[7:6] == FORM_FIXB) |=> MEM_REQ.addr[11:4] == PAGE_FIXB)
        else $error("fixed page bit address wrong");
    skip_clear_a: assert property (
        (state_r == ST_BIT_RD && op_r == OP_TSC && rbit) |=> SKIP_TAKEN && !DONE && MEM_REQ.wr)
        else $error("set bit did not clear and skip");
    always_clear_a: assert property (
        (state_r == ST_BIT_WB && op_r == OP_TSC) |-> MEM_REQ.wr && MEM_REQ.wdata[bit_r] == 1'b0
            && MEM_REQ.addr == $past(MEM_REQ.addr))
        else $error("tested bit not cleared");
    call_walk_a: assert property (
        call_start |=> push_walk)
        else $error("long call did not take four cycles");
    ret_push_a: assert property (
        (state_r == ST_CALL_PUSH && step_r == 2'h1) |-> MEM_REQ.wdata == ret_w[7:0]
            && MEM_REQ.addr[7:0] == 8'(ctx_r.sp - 8'h04))
        else $error("return address push wrong");
    sp_drop_a: assert property (
        call_start |-> ##4 SP_OUT == 8'($past(CTX_IN.sp, 4) - SP_DROP))
        else $error("stack pointer not lowered by six");
    flag_push_a: assert property (
        (state_r == ST_CALL_PUSH && step_r == 2'h0) |-> MEM_REQ.wdata == {6'h00, ctx_r.mbank, ctx_r.rbank})
        else $error("bank flag push wrong");
    pc_target_a: assert property (
        call_start |-> ##4 PC_OUT == $past({INSTR.b1[5:0], INSTR.b2}, 4))
        else $error("call target not loaded");
    skip_one_a: assert property (
        (state_r == ST_BIT_WB && SKIP_TAKEN && len_eff == 2'h1) |=> DONE ##1 !BUSY)
        else $error("one-byte skip length wrong");
endmodule : bxz_exec
`default_nettype wire

// ===== bxz_exec_test.sv
/*
 * Self-checking testbench for the bit exclusive-OR, test-skip-clear and long call unit.
 * Assumes the bench itself stands in for the data memory and the core around the unit.
 */
`timescale 1ns/100ps
`default_nettype none
module bxz_exec_test;
    import bxz_pkg::*;

    logic        REF_CLK;
    logic        RSTN;
    logic        START;
    bxz_instr_t  INSTR;
    bxz_ctx_t    CTX_IN;
    logic [1:0]  NEXT_LEN;
    bxz_mem_t    MEM_REQ;
    logic [3:0]  MEM_RDATA;
    logic        CARRY_OUT;
    logic        CARRY_WE;
    logic [13:0] PC_OUT;
    logic        PC_WE;
    logic [7:0]  SP_OUT;
    logic        SP_WE;
    logic        BUSY;
    logic        DONE;
    logic        SKIP_TAKEN;
    logic        BAD_OP;

    logic [3:0]  mem [0:4095];
    logic [11:0] rd_addr;
    int          n_fail;
    int          samples_checked;
    int          done_cyc;
    int          skip_cyc;
    int          bad_cyc;
    int          cwe_cyc;
    int          pwe_cyc;
    int          swe_cyc;
    logic        busy1;

    bxz_exec DUT (
        .REF_CLK    (REF_CLK),
        .RSTN       (RSTN),
        .START      (START),
        .INSTR      (INSTR),
        .CTX_IN     (CTX_IN),
        .NEXT_LEN   (NEXT_LEN),
        .MEM_REQ    (MEM_REQ),
        .MEM_RDATA  (MEM_RDATA),
        .CARRY_OUT  (CARRY_OUT),
        .CARRY_WE   (CARRY_WE),
        .PC_OUT     (PC_OUT),
        .PC_WE      (PC_WE),
        .SP_OUT     (SP_OUT),
        .SP_WE      (SP_WE),
        .BUSY       (BUSY),
        .DONE       (DONE),
        .SKIP_TAKEN (SKIP_TAKEN),
        .BAD_OP     (BAD_OP)
    );

    // Memory answers reads at once and takes writes on the edge ending the request.
    assign MEM_RDATA = MEM_REQ.rd ? mem[MEM_REQ.addr] : ~mem[MEM_REQ.addr];
    always @(posedge REF_CLK) begin
        if (MEM_REQ.wr === 1'b1) begin
            mem[MEM_REQ.addr] <= MEM_REQ.wdata[3:0];
            if (MEM_REQ.pair === 1'b1) begin
                mem[MEM_REQ.addr_hi] <= MEM_REQ.wdata[7:4];
            end
        end
    end

    always #50 REF_CLK = ~REF_CLK;

    task automatic wrap_up();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chk_cyc(input string name, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            n_fail++;
            $display("BAD %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chk_cyc

    task automatic idle(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask : idle

    // Lets one edge pass so the unit is idle again, issues one instruction and records when DONE, SKIP_TAKEN, BAD_OP and each write enable answered.
    task automatic run_op(input bxz_instr_t ins, input bxz_ctx_t ctx, input logic [1:0] nlen);
        @(negedge REF_CLK);
        START = 1'b1;
        INSTR = ins;
        CTX_IN = ctx;
        NEXT_LEN = nlen;
        {done_cyc, skip_cyc, bad_cyc, cwe_cyc, pwe_cyc, swe_cyc} = '0;
        for (int cyc = 1; cyc <= 8; cyc++) begin
            @(negedge REF_CLK);
            START = 1'b0;
            if (cyc == 1) begin
                rd_addr = MEM_REQ.addr;
                busy1 = BUSY;
            end
            if (SKIP_TAKEN === 1'b1) skip_cyc = cyc;
            if (CARRY_WE === 1'b1) cwe_cyc = cyc;
            if (PC_WE === 1'b1) pwe_cyc = cyc;
            if (SP_WE === 1'b1) swe_cyc = cyc;
            if (BAD_OP === 1'b1) bad_cyc = cyc;
            if (DONE === 1'b1 || bad_cyc != 0) begin
                done_cyc = (DONE === 1'b1) ? cyc : 0;
                break;
            end
        end
    endtask : run_op

    // Builds the second byte, nibble address and bit number of one addressing form.
    task automatic bit_operand(input int f, input logic [3:0] a4, input logic [1:0] b,
                               output logic [7:0] b1, output logic [11:0] a, output logic [1:0] k);
        k = b;
        case (f)
            0: begin b1 = {2'b00, b, a4}; a = {4'h0, 4'h2, a4}; end
            1: begin b1 = {2'b01, 2'b00, a4}; a = {4'hF, 2'b11, a4, 2'b10}; k = 2'h1; end
            2: begin b1 = {2'b10, b, a4}; a = {8'hFB, a4}; end
            default: begin b1 = {2'b11, b, a4}; a = {8'hFF, a4}; end
        endcase
    endtask : bit_operand

    task automatic t_xor();
        logic [7:0]  b1;
        logic [11:0] a;
        logic [1:0]  k;
        logic [3:0]  v;
        for (int f = 0; f < 4; f++) begin
            bit_operand(f, 4'(f * 5 + 3), 2'(f + 1), b1, a, k);
            v = 4'h5 ^ 4'(f);
            mem[a] = v;
            run_op({OPC_BIT_XOR, b1, 8'h00}, {14'h0100, 8'h40, 4'h9, 4'h2, f[1], 1'b0, 1'b0}, 2'h1);
            chk("xor address", 16'(a), 16'(rd_addr));
            chk_cyc("xor done cycle", 2, done_cyc);
            chk_cyc("xor carry write cycle", 2, cwe_cyc);
            chk("xor carry", 16'(f[1] ^ v[k]), 16'(CARRY_OUT));
            idle(1);
            chk("xor source kept", 16'(v), 16'(mem[a]));
        end
    endtask : t_xor

    task automatic t_tsc();
        logic [7:0]  b1;
        logic [11:0] a;
        logic [1:0]  k;
        logic [3:0]  v;
        logic [1:0]  n;
        for (int f = 0; f < 4; f++) begin
            bit_operand(f, 4'(f * 3 + 1), 2'(f + 2), b1, a, k);
            v = f[0] ? 4'hF : ~(4'h1 << k);
            n = (f == 1) ? 2'h2 : 2'h0;
            mem[a] = v;
            run_op({OPC_BIT_TSC, b1, 8'h00}, {14'h0200, 8'h40, 4'h9, 4'h2, 1'b0, 1'b0, 1'b0}, n);
            chk("clear address", 16'(a), 16'(rd_addr));
            chk_cyc("skip cycle", f[0] ? 2 : 0, skip_cyc);
            chk_cyc("clear done cycle", f[0] ? 2 + ((n == 0) ? 1 : n) : 2, done_cyc);
            idle(1);
            chk("bit cleared", 16'(v & ~(4'h1 << k)), 16'(mem[a]));
        end
    endtask : t_tsc

    task automatic t_call(input logic [13:0] pc, input logic [7:0] sp, input logic [13:0] tgt,
                          input logic mb, input logic rb);
        logic [13:0] ret;
        logic [3:0]  exp [0:6];
        ret = pc + 14'h0003;
        exp = '{4'h0, {2'b00, mb, rb}, ret[7:4], ret[3:0], {2'b00, ret[13:12]}, ret[11:8], 4'h5};
        for (int i = 0; i < 7; i++) mem[{4'h0, 8'(sp - 8'(i + 1))}] = (i == 6) ? 4'h5 : 4'hA;
        run_op({OPC_LCALL, {2'b01, tgt[13:8]}, tgt[7:0]}, {pc, sp, 4'h0, 4'h0, 1'b0, mb, rb}, 2'h1);
        chk_cyc("call done cycle", 4, done_cyc);
        chk_cyc("call pc write cycle", 4, pwe_cyc);
        chk_cyc("call sp write cycle", 4, swe_cyc);
        chk("call target", 16'(tgt), 16'(PC_OUT));
        chk("call stack pointer", 16'(8'(sp - 8'h06)), 16'(SP_OUT));
        for (int i = 0; i < 7; i++) begin
            chk("call stack nibble", 16'(exp[i]), 16'(mem[{4'h0, 8'(sp - 8'(i + 1))}]));
        end
    endtask : t_call

    task automatic t_bad();
        bxz_instr_t bad [0:2];
        bad = '{{8'h00, 8'h41, 8'h00}, {OPC_LCALL, 8'h81, 8'h00}, {OPC_BIT_XOR, 8'h53, 8'h00}};
        for (int i = 0; i < 3; i++) begin
            run_op(bad[i], {14'h0300, 8'h40, 4'h9, 4'h2, 1'b0, 1'b0, 1'b0}, 2'h1);
            chk_cyc("refusal cycle", 1, bad_cyc);
            chk("refused busy", 16'h0000, 16'(busy1));
            chk_cyc("refused done", 0, done_cyc);
        end
    endtask : t_bad

    initial begin
        #(100 * 2000);
        n_fail++;
        wrap_up();
    end

    initial begin
        REF_CLK = 1'b0;
        RSTN = 1'b0;
        START = 1'b0;
        INSTR = '0;
        CTX_IN = '0;
        NEXT_LEN = 2'h1;
        n_fail = 0;
        samples_checked = 0;
        for (int i = 0; i < 4096; i++) mem[i] = 4'(i);
        repeat (5) @(negedge REF_CLK);
        RSTN = 1'b1;
        t_xor();
        t_tsc();
        t_call(14'h0123, 8'h00, 14'h0E3F, 1'b1, 1'b0);
        t_call(14'h3FFE, 8'h10, 14'h3FFF, 1'b0, 1'b1);
        t_bad();
        t_call(14'h2ABC, 8'h03, 14'h1234, 1'b1, 1'b1);
        idle(2);
        wrap_up();
    end
endmodule : bxz_exec_test
`default_nettype wire
